// file: shared/rsc_pkg.sv
package rsc_pkg;
   // Register offsets on the serial host port
   localparam logic [5:0] ADDR_CTL  = 6'h06;
   localparam logic [5:0] ADDR_IEN  = 6'h07;
   localparam logic [5:0] ADDR_STAT = 6'h08;
   localparam logic [5:0] ADDR_DATB = 6'h0B;
   // Reset values
   localparam logic [7:0] CTL_RST   = 8'h03;
   localparam logic [7:0] IEN_RST   = 8'h00;
   // Field positions
   localparam int CTL_MODE_BIT = 3;
   localparam int CTL_LEN_MSB  = 2;
   localparam int CMD_WR_BIT   = 7;
   localparam int IEN_B_LSB    = 4;
   // Frame counts
   localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;
   localparam logic [4:0] LAST_CMD_BIT     = 5'h07;
   localparam logic [4:0] LAST_FRAME_BIT   = 5'h0F;
   // Host-domain cycles that the link reset is stretched by
   localparam logic [5:0] LINK_RST_HOLD    = 6'h3F;

   // Word handed from the bit domain to the host domain
   typedef struct packed {
      logic       eof;
      logic       xfer;
      logic       all_valid;
      logic [7:0] data;
   } rsc_xfer_s;

   // Pending events, ordered as the enable nibble
   typedef struct packed {
      logic under;
      logic over;
      logic eof;
      logic full;
   } rsc_evt_s;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_CMD  = 2'b01,
      SPI_DATA = 2'b10,
      SPI_DONE = 2'b11
   } rsc_spi_e;

   // Settled value: follows stages 2 and 3 only when they agree
   function automatic logic settle(input logic s2, input logic s3, input logic prev);
      settle = (s2 == s3) ? s3 : prev;
   endfunction
endpackage

// file: rtl/rsc_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Receive bit-time logic, clocked by the correlator bit clock
module rsc_link (
   input  wire logic               link_clk,   // Bit-time clock
   input  wire logic               rst_req,    // Reset from host domain
   input  wire logic [3:0]         ctl,        // Mode and gap length, host domain
   input  wire logic               corr_valid, // Bit correlated this bit time
   input  wire logic               corr_data,  // Correlated bit value
   output rsc_pkg::rsc_xfer_s      xfer_word,  // Held transfer word
   output logic                    xfer_tog,   // Toggles per transfer
   output logic                    ser_data,   // Bit-serial data out
   output logic                    ser_valid   // Bit-serial valid out
);
   typedef struct packed {
      logic [2:0]         rst_sy;
      logic [3:0]         c1;
      logic [3:0]         c2;
      logic [3:0]         c3;
      logic               rst;
      logic [3:0]         ctl;
      logic [7:0]         shf;
      logic [2:0]         cnt;
      logic [3:0]         gap;
      logic               seen;
      logic               tog;
      rsc_pkg::rsc_xfer_s word;
      logic               sdat;
      logic               sval;
   } rsc_link_s;

   rsc_link_s q;
   rsc_link_s d;
   logic [3:0] gap_nx;

   // Next state of the bit-time logic
   always_comb begin
      d = q;
      gap_nx = q.gap + 4'h1;
      d.rst_sy = {q.rst_sy[1:0], rst_req};
      d.c1 = ctl;
      d.c2 = q.c1;
      d.c3 = q.c2;
      d.rst = rsc_pkg::settle(q.rst_sy[1], q.rst_sy[2], q.rst);
      // Whole word only, so a mixed old/new value never lands
      d.ctl = (q.c2 == q.c3) ? q.c3 : q.ctl;
      if (q.rst) begin
         d.shf  = 8'h00;
         d.cnt  = 3'h0;
         d.gap  = 4'h0;
         d.seen = 1'b0;
         d.tog  = 1'b0;
         d.word = '0;
         d.sdat = 1'b0;
         d.sval = 1'b0;
      end else begin
         // Data pin always follows; valid pin only in bit-serial mode
         d.sdat = corr_data;
         d.sval = corr_valid & ~q.ctl[rsc_pkg::CTL_MODE_BIT];
         if (corr_valid) begin
            d.shf  = {q.shf[6:0], corr_data};
            d.seen = 1'b1;
            d.gap  = 4'h0;
            d.cnt  = q.cnt + 3'h1;
            if (q.cnt == rsc_pkg::LAST_BIT_OF_BYTE) begin
               // Whole byte: hand over in byte-wide mode only
               if (q.ctl[rsc_pkg::CTL_MODE_BIT]) begin
                  d.word = '{eof: 1'b0, xfer: 1'b1, all_valid: 1'b1,
                             data: {q.shf[6:0], corr_data}};
                  d.tog  = ~q.tog;
               end
            end
         end else if (q.seen) begin
            d.gap = gap_nx;
            // Gap beyond programmed length ends the frame
            if (gap_nx > {1'b0, q.ctl[rsc_pkg::CTL_LEN_MSB:0]}) begin
               d.seen = 1'b0;
               d.gap  = 4'h0;
               d.cnt  = 3'h0;
               if (q.ctl[rsc_pkg::CTL_MODE_BIT]) begin
                  d.word = '{eof: 1'b1, xfer: (q.cnt != 3'h0), all_valid: 1'b0,
                             data: q.shf};
                  d.tog  = ~q.tog;
               end
            end
         end
      end
   end

   // State register
   always_ff @(posedge link_clk) begin
      q <= d;
   end

   assign xfer_word = q.word;
   assign xfer_tog  = q.tog;
   assign ser_data  = q.sdat;
   assign ser_valid = q.sval;
endmodule // rsc_link

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Control bit 3 picks byte-wide mode (1) or bit-serial pin mode (0).
// - Byte-wide mode hands payload a byte per access via data registers.
// - Bit-serial mode moves one bit per time on data and valid pins.
// - Control bits 2:0 set end-of-frame gap in bit times.
// - Gap counting starts after a valid bit; counts bit times without data.
// - End of frame moves pending data to the data register and flags event.
// - Gap length zero ends frame on first invalid bit after valid data.
// - Enable bit 7 gates channel B underflow onto the interrupt.
// - Reading channel B data at 0x0B while empty flags underflow.
// - Enable bit 6 gates channel B overflow onto the interrupt.
// - New data loaded before the previous was read flags overflow.
// - Enable bit 5 gates channel B end of frame onto the interrupt.
// - End of frame when invalid bits after a valid one exceed gap length.
// - Reading the status register clears pending end of frame.
// - Enable bit 4 gates channel B full onto the interrupt.
// - Full raised on transfer of a whole byte or a partial one at frame end.
// - Status shows combined overflow/underflow for B; status read clears it.
// - Enable bits 3..0 gate channel A underflow, overflow, end, full.
module rsc_top (
   input  wire logic       mclk,                  // Device clock
   input  wire logic       sys_rst,               // Synchronous reset
   input  wire logic       spi_sck,               // Host serial clock
   input  wire logic       spi_ss_n,              // Host select, active low
   input  wire logic       spi_mosi,              // Host to device data
   output logic            spi_miso,              // Device to host data
   output logic            spi_miso_oe,           // Drive enable for miso
   output logic            irq,                   // Interrupt request
   input  wire logic       link_clk,              // Receive bit-time clock
   input  wire logic       corr_valid,            // Bit correlated
   input  wire logic       corr_data,             // Correlated bit
   input  wire logic [3:0] chan_a_evt,            // Channel A event pulses
   output logic            serial_data_pin,       // Bit-serial data
   output logic            serial_data_valid_pin  // Bit-serial valid
);
   typedef struct packed {
      logic [2:0]         sck_sy;
      logic [2:0]         ss_sy;
      logic [2:0]         mosi_sy;
      logic [2:0]         tg_sy;
      logic               sck;
      logic               ss_n;
      logic               mosi;
      logic               tg;
      rsc_pkg::rsc_spi_e  st;
      logic [4:0]         bits;
      logic [7:0]         rx;
      logic [7:0]         tx;
      logic [7:0]         cmd;
      logic [7:0]         ctl;
      logic [7:0]         ien;
      rsc_pkg::rsc_evt_s  pb;
      rsc_pkg::rsc_evt_s  pa;
      logic [7:0]         datb;
      logic               has;
      logic               vb;
      logic               miso;
      logic               oe;
      logic               irq;
      logic [5:0]         lrst;
      logic               lrst_on;
   } rsc_top_s;

   rsc_top_s           q;
   rsc_top_s           d;
   rsc_pkg::rsc_xfer_s xw;
   logic               xtog;
   logic               sck_n;
   logic               ss_nx;
   logic               mosi_n;
   logic               tg_n;
   logic               rise;
   logic               fall;
   logic [7:0]         stat;

   // Receive bit-time logic in the link clock domain
   rsc_link u_link (
      .link_clk   (link_clk),
      .rst_req    (q.lrst_on),
      .ctl        (q.ctl[3:0]),
      .corr_valid (corr_valid),
      .corr_data  (corr_data),
      .xfer_word  (xw),
      .xfer_tog   (xtog),
      .ser_data   (serial_data_pin),
      .ser_valid  (serial_data_valid_pin)
   );

   // Status byte seen by the host
   always_comb begin
      stat = {q.vb, q.pb.under | q.pb.over, q.pb.eof, q.pb.full,
              1'b0, q.pa.under | q.pa.over, q.pa.eof, q.pa.full};
   end

   // Next state of host port, registers and events
   always_comb begin
      d = q;
      d.sck_sy  = {q.sck_sy[1:0], spi_sck};
      d.ss_sy   = {q.ss_sy[1:0], spi_ss_n};
      d.mosi_sy = {q.mosi_sy[1:0], spi_mosi};
      d.tg_sy   = {q.tg_sy[1:0], xtog};
      sck_n  = rsc_pkg::settle(q.sck_sy[1], q.sck_sy[2], q.sck);
      ss_nx  = rsc_pkg::settle(q.ss_sy[1], q.ss_sy[2], q.ss_n);
      mosi_n = rsc_pkg::settle(q.mosi_sy[1], q.mosi_sy[2], q.mosi);
      tg_n   = rsc_pkg::settle(q.tg_sy[1], q.tg_sy[2], q.tg);
      rise   = sck_n & ~q.sck;
      fall   = ~sck_n & q.sck;
      d.sck  = sck_n;
      d.ss_n = ss_nx;
      d.mosi = mosi_n;
      d.tg   = tg_n;

      // Host port: command byte then data byte, mode 0
      if (ss_nx) begin
         d.st   = rsc_pkg::SPI_IDLE;
         d.bits = 5'h00;
         d.oe   = 1'b0;
      end else begin
         d.oe = 1'b1;
         case (q.st)
            rsc_pkg::SPI_IDLE: begin
               d.st   = rsc_pkg::SPI_CMD;
               d.bits = 5'h00;
            end
            rsc_pkg::SPI_CMD: begin
               if (rise) begin
                  d.rx   = {q.rx[6:0], mosi_n};
                  d.bits = q.bits + 5'h01;
                  if (q.bits == rsc_pkg::LAST_CMD_BIT) begin
                     d.cmd = {q.rx[6:0], mosi_n};
                     d.st  = rsc_pkg::SPI_DATA;
                  end
               end
            end
            rsc_pkg::SPI_DATA: begin
               if (fall) begin
                  d.miso = q.tx[7];
                  d.tx   = {q.tx[6:0], 1'b0};
               end
               if (rise) begin
                  d.rx   = {q.rx[6:0], mosi_n};
                  d.bits = q.bits + 5'h01;
                  if (q.bits == rsc_pkg::LAST_FRAME_BIT) begin
                     d.st = rsc_pkg::SPI_DONE;
                  end
               end
            end
            rsc_pkg::SPI_DONE: begin
               d.st = rsc_pkg::SPI_DONE;
            end
            default: begin
               d.st = rsc_pkg::SPI_IDLE;
            end
         endcase
      end

      // Read side effects when the command byte completes
      if (q.st == rsc_pkg::SPI_CMD && d.st == rsc_pkg::SPI_DATA &&
          !d.cmd[rsc_pkg::CMD_WR_BIT]) begin
         if (d.cmd[5:0] == rsc_pkg::ADDR_STAT) begin
            d.tx       = stat;
            d.pb.under = 1'b0;
            d.pb.over  = 1'b0;
            d.pb.eof   = 1'b0;
            d.pa       = '0;
         end else if (d.cmd[5:0] == rsc_pkg::ADDR_DATB) begin
            d.tx = q.datb;
            if (q.has) begin
               d.has     = 1'b0;
               d.pb.full = 1'b0;
            end else begin
               d.pb.under = 1'b1;
            end
         end else begin
            case (d.cmd[5:0])
               rsc_pkg::ADDR_CTL: d.tx = {4'h0, q.ctl[3:0]};
               rsc_pkg::ADDR_IEN: d.tx = q.ien;
               default:           d.tx = 8'h00;
            endcase
         end
      end

      // Register writes on the last data bit
      if (q.st == rsc_pkg::SPI_DATA && d.st == rsc_pkg::SPI_DONE &&
          q.cmd[rsc_pkg::CMD_WR_BIT]) begin
         case (q.cmd[5:0])
            rsc_pkg::ADDR_CTL: d.ctl = {4'h0, d.rx[3:0]};
            rsc_pkg::ADDR_IEN: d.ien = d.rx;
            default:           d.ien = q.ien;
         endcase
      end

      // Transfers from the bit domain; sets win over clears
      // Toggles ignored while the link side is still being reset
      if (tg_n != q.tg && !q.lrst_on) begin
         if (xw.xfer) begin
            if (d.has) begin
               d.pb.over = 1'b1;
            end
            d.datb    = xw.data;
            d.has     = 1'b1;
            d.vb      = xw.all_valid;
            d.pb.full = 1'b1;
         end
         if (xw.eof) begin
            d.pb.eof = 1'b1;
         end
      end
      d.pa = d.pa | chan_a_evt;

      // Stretch reset so a slow link clock still sees it
      d.lrst    = (q.lrst == 6'h00) ? q.lrst : q.lrst - 6'h01;
      d.lrst_on = (q.lrst != 6'h00);

      // Enabled pending events drive the request
      d.irq = |(d.pb & d.ien[7:rsc_pkg::IEN_B_LSB]) |
              |(d.pa & d.ien[rsc_pkg::IEN_B_LSB-1:0]);

      if (sys_rst) begin
         d.st   = rsc_pkg::SPI_IDLE;
         d.bits = 5'h00;
         d.rx   = 8'h00;
         d.tx   = 8'h00;
         d.cmd  = 8'h00;
         d.ctl  = rsc_pkg::CTL_RST;
         d.ien  = rsc_pkg::IEN_RST;
         d.pb   = '0;
         d.pa   = '0;
         d.datb = 8'h00;
         d.has  = 1'b0;
         d.vb   = 1'b0;
         d.miso = 1'b0;
         d.oe   = 1'b0;
         d.irq  = 1'b0;
         d.sck  = 1'b0;
         d.ss_n = 1'b1;
         d.mosi = 1'b0;
         d.lrst    = rsc_pkg::LINK_RST_HOLD;
         d.lrst_on = 1'b1;                 // Toggle copy keeps following
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      q <= d;
   end

   assign spi_miso    = q.miso;
   assign spi_miso_oe = q.oe;
   assign irq         = q.irq;
endmodule // rsc_top

// file: testbench/rsc_top_sva.sv
`timescale 1ns/1ps
module rsc_top_chk (
   input wire logic       mclk,                 // Clock
   input wire logic       sys_rst,              // Reset
   input wire logic       spi_sck,              // Serial clock
   input wire logic       spi_ss_n,             // Select
   input wire logic       spi_mosi,             // Host data
   input wire logic       spi_miso,             // Device data
   input wire logic       spi_miso_oe,          // Miso enable
   input wire logic       irq,                  // Interrupt
   input wire logic       link_clk,             // Bit clock
   input wire logic       corr_valid,           // Bit valid
   input wire logic       corr_data,            // Bit value
   input wire logic [3:0] chan_a_evt,           // Channel A events
   input wire logic       serial_data_pin,      // Serial data
   input wire logic       serial_data_valid_pin // Serial valid
);
   logic [7:0] quiet_q;
   logic [7:0] quiet_d;
   // Cycles since anything that may raise an event
   always_comb begin
      quiet_d = (quiet_q == 8'hFF) ? quiet_q : quiet_q + 8'h01;
      if (chan_a_evt != 4'h0 || !spi_ss_n || corr_valid) quiet_d = 8'h00;
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) quiet_q <= 8'h00;
      else quiet_q <= quiet_d;
   end
   ////////////////////////////////////////////////////////////////////////////
   chk_oe_on: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(spi_ss_n) |-> ##[2:6] spi_miso_oe) else $error("miso enable late");
   chk_oe_off: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(spi_ss_n) |-> ##[2:6] !spi_miso_oe) else $error("miso enable stuck");
   chk_rst_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
      $past(sys_rst) |-> !irq && !spi_miso_oe) else $error("outputs live after reset");
   chk_irq_fall_sel: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(irq) |-> !spi_ss_n) else $error("irq dropped without host access");
   chk_miso_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
      $changed(spi_miso) |-> !$past(spi_sck, 1) && !$past(spi_sck, 2))
      else $error("miso moved while sck high");
   chk_irq_cause: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(irq) |-> quiet_q < 8'h64) else $error("irq rose with no cause");
   chk_valid_copy: assert property (@(posedge link_clk)
      serial_data_valid_pin |-> $past(corr_valid)) else $error("serial valid wrong");
   chk_data_copy: assert property (@(posedge link_clk)
      serial_data_valid_pin |-> serial_data_pin == $past(corr_data))
      else $error("serial data wrong");
   // Main scenarios reached
   cover property (@(posedge mclk) $rose(irq));
   cover property (@(posedge mclk) $fell(irq));
   cover property (@(posedge link_clk) serial_data_valid_pin);
endmodule // rsc_top_chk

bind rsc_top rsc_top_chk chk_u (.mclk(mclk), .sys_rst(sys_rst), .spi_sck(spi_sck),
   .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe), .irq(irq), .link_clk(link_clk), .corr_valid(corr_valid),
   .corr_data(corr_data), .chan_a_evt(chan_a_evt), .serial_data_pin(serial_data_pin),
   .serial_data_valid_pin(serial_data_valid_pin));

// file: testbench/rsc_host_model.sv
`timescale 1ns/1ps
module rsc_host_model #(parameter int HALF = 10) (
   input  wire logic       mclk,     // Clock
   input  wire logic       go,       // Start access
   input  wire logic       wr,       // Write when high
   input  wire logic [5:0] addr,     // Offset
   input  wire logic [7:0] wdata,    // Write data
   input  wire logic       spi_miso, // Device data
   output logic            spi_sck,  // Serial clock
   output logic            spi_ss_n, // Select
   output logic            spi_mosi, // Host data
   output logic            done,     // Access over
   output logic [7:0]      rdata     // Read data
);
   logic [15:0] frm;
   initial begin
      spi_sck = 1'b0;
      spi_ss_n = 1'b1;
      spi_mosi = 1'b0;
      done = 1'b0;
      rdata = 8'h00;
   end
   // One framed access, command then data, MSB first, mode 0
   always begin
      @(posedge mclk iff go);
      frm = {wr, 1'b0, addr, wdata};
      spi_ss_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi <= frm[i];
         repeat (HALF) @(posedge mclk);
         spi_sck <= 1'b1;
         if (i < 8) rdata[i] <= spi_miso;
         repeat (HALF) @(posedge mclk);
         spi_sck <= 1'b0;
      end
      repeat (HALF) @(posedge mclk);
      spi_ss_n <= 1'b1;
      spi_mosi <= ~spi_mosi; // Released line shows no stale bit
      done <= 1'b1;
      @(posedge mclk);
      done <= 1'b0;
   end
endmodule // rsc_host_model

// file: testbench/rsc_top_tb.sv
`timescale 1ns/1ps
module rsc_top_tb;
   logic       mclk, sys_rst, link_clk, corr_valid, corr_data, go, wr, done, saw_val;
   logic       spi_sck, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe, irq, sdat, sval;
   logic [3:0] chan_a_evt;
   logic [5:0] addr;
   logic [7:0] wdata, rdata;
   int         n_fail, check_count;

   rsc_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .irq(irq),
      .link_clk(link_clk), .corr_valid(corr_valid), .corr_data(corr_data),
      .chan_a_evt(chan_a_evt), .serial_data_pin(sdat), .serial_data_valid_pin(sval));
   rsc_host_model host_u (.mclk(mclk), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
      .spi_miso(spi_miso), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
      .done(done), .rdata(rdata));
   ////////////////////////////////////////////////////////////////////////////
   // Clocks, unrelated in phase
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      link_clk = 1'b0;
      #7.3;
      forever #16 link_clk = ~link_clk;
   end
   // Notes any serial valid strobe
   always @(posedge link_clk) if (sval === 1'b1) saw_val <= 1'b1;
   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (n_fail == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      int k;
      wr <= w;
      addr <= a;
      wdata <= d;
      go <= 1'b1;
      for (k = 0; k < 600 && done !== 1'b1; k++) @(posedge mclk);
      go <= 1'b0;
      if (k == 600) begin
         n_fail++;
         wrap_up();
      end
      repeat (8) @(posedge mclk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      cmp(rdata, exp);
   endtask
   task automatic irq_is(input logic e);
      cmp({7'h00, irq}, {7'h00, e});
   endtask
   // Sends n bit times, then a long idle gap
   task automatic bits(input logic [15:0] v, input logic [15:0] d, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge link_clk);
         corr_valid <= v[i];
         corr_data <= v[i] ? d[i] : ~corr_data;
      end
      @(posedge link_clk);
      corr_valid <= 1'b0;
      repeat (12) @(posedge link_clk);
      repeat (8) @(posedge mclk);
   endtask
   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(6'h06, 8'h03);
      rd(6'h07, 8'h00);
      rd(6'h08, 8'h00);
      rd(6'h3F, 8'h00);
      acc(1'b1, 6'h06, 8'h08);
      rd(6'h06, 8'h08);
   endtask
   task automatic t_byte;
      acc(1'b1, 6'h06, 8'h0B);
      acc(1'b1, 6'h07, 8'h10);
      saw_val = 1'b0;
      bits(16'h00FF, 16'h00A5, 8);
      irq_is(1'b1);
      cmp({7'h00, saw_val}, 8'h00);
      rd(6'h08, 8'hB0);
      rd(6'h0B, 8'hA5);
      irq_is(1'b0);
   endtask
   task automatic t_gap;
      acc(1'b1, 6'h07, 8'h20);
      bits(16'h0071, 16'h0051, 7);
      irq_is(1'b1);
      rd(6'h08, 8'h30);
      irq_is(1'b0);
      acc(1'b0, 6'h0B, 8'h00);
      cmp(rdata & 8'h0F, 8'h0B);
   endtask
   task automatic t_len0;
      acc(1'b1, 6'h06, 8'h08);
      acc(1'b1, 6'h07, 8'h40);
      bits(16'h0005, 16'h0004, 3);
      irq_is(1'b1);
      rd(6'h08, 8'h70);
      irq_is(1'b0);
      acc(1'b0, 6'h0B, 8'h00);
      cmp(rdata & 8'h01, 8'h00);
   endtask
   task automatic t_under;
      acc(1'b1, 6'h07, 8'h80);
      acc(1'b0, 6'h0B, 8'h00);
      irq_is(1'b1);
      rd(6'h08, 8'h40);
      irq_is(1'b0);
      acc(1'b1, 6'h07, 8'h00);
      acc(1'b0, 6'h0B, 8'h00);
      irq_is(1'b0);
      rd(6'h08, 8'h40);
   endtask
   task automatic t_chan_a;
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 6'h07, 8'h01 << i);
         chan_a_evt <= ~(4'h1 << i);
         @(posedge mclk);
         chan_a_evt <= 4'h0;
         repeat (4) @(posedge mclk);
         irq_is(1'b0);
         chan_a_evt <= 4'h1 << i;
         @(posedge mclk);
         chan_a_evt <= 4'h0;
         repeat (4) @(posedge mclk);
         irq_is(1'b1);
         rd(6'h08, 8'h07);
         irq_is(1'b0);
      end
   endtask
   task automatic t_serial;
      acc(1'b1, 6'h06, 8'h03);
      saw_val = 1'b0;
      bits(16'h00FF, 16'h005A, 8);
      cmp({7'h00, saw_val}, 8'h01);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      go = 1'b0;
      wr = 1'b0;
      addr = 6'h00;
      wdata = 8'h00;
      corr_valid = 1'b0;
      corr_data = 1'b0;
      chan_a_evt = 4'h0;
      saw_val = 1'b0;
      n_fail = 0;
      check_count = 0;
      do_reset();
      t_regs();
      t_byte();
      t_gap();
      t_len0();
      t_under();
      t_chan_a();
      t_serial();
      do_reset();
      rd(6'h06, 8'h03);
      wrap_up();
   end
endmodule // rsc_top_tb
